// ===== gpp_pkg.sv
package gpp_pkg;

    // Port geometry
    localparam int unsigned NUM_PINS       = 26;
    localparam int unsigned NUM_TMR_CLK    = 3;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;

    // Timing: clock period in picoseconds, latencies and hold in system clock cycles
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned OUT_MIN_CYC    = 3;
    localparam int unsigned DIN_LAT_CYC    = 5;
    localparam int unsigned FLAG_LAT_CYC   = 7;
    localparam int unsigned IRQ_LAT_CYC    = 8;
    localparam int unsigned HOLD_CNT_W     = 2;
    localparam logic [HOLD_CNT_W-1:0] HOLD_RELOAD = HOLD_CNT_W'(OUT_MIN_CYC - 1);

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_DIR      = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DOUT     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DIN      = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PD_DIS   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_EDGE_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FLAG     = 8'h14;
    localparam logic [ADDR_W-1:0] REG_FLAG_CLR = 8'h18;
    localparam logic [ADDR_W-1:0] REG_INT_EN   = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_DED_OUT  = 8'h20;
    localparam logic [ADDR_W-1:0] REG_MUX_SEL  = 8'h24;

    // Reset values
    localparam logic [NUM_PINS-1:0] DIR_RST      = 26'h0000000;
    localparam logic [NUM_PINS-1:0] DOUT_RST     = 26'h0000000;
    localparam logic [NUM_PINS-1:0] PD_DIS_RST   = 26'h0000000;
    localparam logic [NUM_PINS-1:0] EDGE_SEL_RST = 26'h0000000;
    localparam logic [NUM_PINS-1:0] INT_EN_RST   = 26'h0000000;
    localparam logic [NUM_PINS-1:0] MUX_SEL_RST  = 26'h0000000;
    localparam logic                DED_OUT_RST  = 1'b0;
    localparam int unsigned         DED_OUT_BIT  = 0;

    // Pins whose input level feeds each timer clock
    localparam int unsigned TMR_PIN0 = 0;
    localparam int unsigned TMR_PIN1 = 1;
    localparam int unsigned TMR_PIN2 = 2;

endpackage : gpp_pkg

// ===== gpp_hold.sv
`timescale 1ns/10ps
// Output pacer: once the level changes, it holds for a fixed number of cycles
module gpp_hold
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    // Requested and paced level
    input  wire logic req_i,
    output logic      lvl_o
);

    logic [HOLD_CNT_W-1:0] cnt;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_o <= 1'b0;
            cnt   <= '0;
        end else if (cnt != '0) begin
            cnt <= cnt - HOLD_CNT_W'(1);
        end else if (req_i != lvl_o) begin
            lvl_o <= req_i;
            cnt   <= HOLD_RELOAD;
        end
    end

endmodule : gpp_hold

// ===== gpp_port.sv
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - Software sets each pin as input or output.
// - An output pin drives the last value software wrote.
// - Reading the input register returns the pin's present level.
// - Twenty-six two-way pins plus one dedicated output.
// - Each pin has a pulldown software can disable per pin.
// - Each pin can raise an edge interrupt, rising or falling per pin.
// - Every level the port itself drives lasts at least three clock periods; peripheral-owned pins pass unpaced.
// - Pin change seen in input 5, flag 7, interrupt 8 cycles.
// - Selected pin input levels are routed out as timer clocks.
// - A multiplex selection decides whether the port or a peripheral owns a pin.
module gpp_port
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    // Register port
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [DATA_W-1:0]   wr_data_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [DATA_W-1:0]   rd_data_o,
    // Interrupt
    output logic                     irq_o,
    // General-purpose pins
    input  wire logic [NUM_PINS-1:0] gen_pin_n_i,
    output logic      [NUM_PINS-1:0] gen_pin_n_o,
    output logic      [NUM_PINS-1:0] gen_pin_n_oe_o,
    output logic      [NUM_PINS-1:0] pin_pulldown_en_o,
    // Dedicated output
    output logic                     dedicated_flag_output_o,
    // Shared peripheral functions
    input  wire logic [NUM_PINS-1:0] periph_out_i,
    input  wire logic [NUM_PINS-1:0] periph_oe_i,
    output logic      [NUM_PINS-1:0] periph_in_o,
    // Timer clock sources
    output logic      [NUM_TMR_CLK-1:0] timer_clk_o
);

    function automatic logic [DATA_W-1:0] ext32(input logic [NUM_PINS-1:0] v);
        ext32 = {{(DATA_W - NUM_PINS){1'b0}}, v};
    endfunction : ext32

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction : hit

    // Shared select: a set bit hands the pin to the peripheral
    function automatic logic [NUM_PINS-1:0] pin_pick(input logic [NUM_PINS-1:0] sel,
                                                      input logic [NUM_PINS-1:0] per,
                                                      input logic [NUM_PINS-1:0] own);
        pin_pick = (sel & per) | (~sel & own);
    endfunction : pin_pick

    // Software state
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] dout;
    logic [NUM_PINS-1:0] pd_dis;
    logic [NUM_PINS-1:0] edge_sel;
    logic [NUM_PINS-1:0] int_en;
    logic [NUM_PINS-1:0] mux_sel;
    logic                ded_out;

    // Input path
    logic [NUM_PINS-1:0] sync_a;
    logic [NUM_PINS-1:0] sync_b;
    logic [NUM_PINS-1:0] din;
    logic [NUM_PINS-1:0] prev;
    logic [NUM_PINS-1:0] edge_hit;
    logic [NUM_PINS-1:0] flag;
    logic [NUM_PINS-1:0] flag_clr;

    // Paced output levels
    logic [NUM_PINS-1:0] paced;
    logic                ded_paced;

    // Read path
    logic [DATA_W-1:0]   next_rd_data;

    // Writes
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dir <= DIR_RST;
        end else if (wr_i && hit(addr_i, REG_DIR)) begin
            dir <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dout <= DOUT_RST;
        end else if (wr_i && hit(addr_i, REG_DOUT)) begin
            dout <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_dis <= PD_DIS_RST;
        end else if (wr_i && hit(addr_i, REG_PD_DIS)) begin
            pd_dis <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_sel <= EDGE_SEL_RST;
        end else if (wr_i && hit(addr_i, REG_EDGE_SEL)) begin
            edge_sel <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int_en <= INT_EN_RST;
        end else if (wr_i && hit(addr_i, REG_INT_EN)) begin
            int_en <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mux_sel <= MUX_SEL_RST;
        end else if (wr_i && hit(addr_i, REG_MUX_SEL)) begin
            mux_sel <= wr_data_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ded_out <= DED_OUT_RST;
        end else if (wr_i && hit(addr_i, REG_DED_OUT)) begin
            ded_out <= wr_data_i[DED_OUT_BIT];
        end
    end

    // Clear strobe from the write-only clear register
    always_comb begin
        flag_clr = '0;
        if (wr_i && hit(addr_i, REG_FLAG_CLR)) begin
            flag_clr = wr_data_i[NUM_PINS-1:0];
        end
    end

    // Input synchroniser; first stage read only by the second
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a <= '0;
        end else begin
            sync_a <= gen_pin_n_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_b <= '0;
        end else begin
            sync_b <= sync_a;
        end
    end

    // Readable input level, three edges behind the pin
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            din <= '0;
        end else begin
            din <= sync_b;
        end
    end

    // Edge history; one cycle behind the second stage so each edge shows once
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev <= '0;
        end else begin
            prev <= sync_b;
        end
    end

    // Rising edge when select is 0, falling when 1
    always_comb begin
        edge_hit = (sync_b & ~prev & ~edge_sel) | (~sync_b & prev & edge_sel);
    end

    // Sticky flags; a new edge wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag <= '0;
        end else begin
            flag <= (flag & ~flag_clr) | edge_hit;
        end
    end

    // Registered so a clear in flight never glitches the line
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flag & int_en);
        end
    end

    // Output pacing, one pacer per pin plus the dedicated line
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pace
        gpp_hold u_hold (
            .core_clk_i (core_clk_i),
            .nrst_i     (nrst_i),
            .req_i      (dout[g]),
            .lvl_o      (paced[g])
        );
    end

    gpp_hold u_ded_hold (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .req_i      (ded_out),
        .lvl_o      (ded_paced)
    );

    // Pin drivers; a peripheral owns a pin when its select bit is set
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gen_pin_n_o <= '0;
        end else begin
            gen_pin_n_o <= pin_pick(mux_sel, periph_out_i, paced);
        end
    end

    // Driven only while the direction bit, or the owning peripheral, asks
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gen_pin_n_oe_o <= '0;
        end else begin
            gen_pin_n_oe_o <= pin_pick(mux_sel, periph_oe_i, dir);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dedicated_flag_output_o <= DED_OUT_RST;
        end else begin
            dedicated_flag_output_o <= ded_paced;
        end
    end

    // Pulldowns stay on through reset so undriven pins read low
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_pulldown_en_o <= '1;
        end else begin
            pin_pulldown_en_o <= ~pd_dis;
        end
    end

    // Synchronised levels to peripherals and timers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            periph_in_o <= '0;
        end else begin
            periph_in_o <= sync_b & mux_sel;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_clk_o <= '0;
        end else begin
            timer_clk_o <= {sync_b[TMR_PIN2], sync_b[TMR_PIN1], sync_b[TMR_PIN0]};
        end
    end

    // Read data, valid the cycle after the strobe only
    // Write-only clear register and holes fall to zero
    always_comb begin
        next_rd_data = '0;
        if (rd_i) begin
            unique case (addr_i)
                REG_DIR:      next_rd_data = ext32(dir);
                REG_DOUT:     next_rd_data = ext32(dout);
                REG_DIN:      next_rd_data = ext32(din);
                REG_PD_DIS:   next_rd_data = ext32(pd_dis);
                REG_EDGE_SEL: next_rd_data = ext32(edge_sel);
                REG_FLAG:     next_rd_data = ext32(flag);
                REG_INT_EN:   next_rd_data = ext32(int_en);
                REG_MUX_SEL:  next_rd_data = ext32(mux_sel);
                REG_DED_OUT:  next_rd_data = {{(DATA_W - 1){1'b0}}, ded_out};
                default:      next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule : gpp_port

// ===== gpp_port_assertions.sv
`timescale 1ns/10ps
module gpp_port_checker
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    // Watched ports
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire logic [DATA_W-1:0]      rd_data_o,
    input  wire logic                   irq_o,
    input  wire logic [NUM_PINS-1:0]    gen_pin_n_i,
    input  wire logic [NUM_PINS-1:0]    gen_pin_n_o,
    input  wire logic [NUM_PINS-1:0]    gen_pin_n_oe_o,
    input  wire logic [NUM_PINS-1:0]    pin_pulldown_en_o,
    input  wire logic                   dedicated_flag_output_o,
    input  wire logic [NUM_TMR_CLK-1:0] timer_clk_o
);
    logic [3:0] quiet;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // Cycles since a pin input last moved
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quiet <= 4'h0;
        end else if ($changed(gen_pin_n_i)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    sequence s_held2(sig);
        $stable(sig)[*2];
    endsequence
    sequence s_recent_wr;
        $past(wr_i) || $past(wr_i, 2);
    endsequence
    a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == '0)
        else $error("read data outside reply");
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_hold
        a_pin_hold: assert property ($changed(gen_pin_n_o[i]) |=> s_held2(gen_pin_n_o[i]))
            else $error("pin level too short");
    end
    a_ded_hold: assert property ($changed(dedicated_flag_output_o) |=> s_held2(dedicated_flag_output_o))
        else $error("dedicated level too short");
    a_timer_follow: assert property ($stable(gen_pin_n_i[2:0])[*5] |->
        timer_clk_o == {gen_pin_n_i[TMR_PIN2], gen_pin_n_i[TMR_PIN1], gen_pin_n_i[TMR_PIN0]})
        else $error("timer clock not following pin");
    a_irq_rise_cause: assert property ($rose(irq_o) |-> s_recent_wr or quiet < 4'h8)
        else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property ($fell(irq_o) |-> s_recent_wr)
        else $error("interrupt fell without write");
    a_oe_by_write: assert property ($changed(gen_pin_n_oe_o) |-> s_recent_wr)
        else $error("enable changed without write");
    a_pd_by_write: assert property ($changed(pin_pulldown_en_o) |-> s_recent_wr)
        else $error("pulldown changed without write");
endmodule : gpp_port_checker

bind gpp_port gpp_port_checker u_gpp_port_checker (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .irq_o(irq_o), .gen_pin_n_i(gen_pin_n_i),
    .gen_pin_n_o(gen_pin_n_o), .gen_pin_n_oe_o(gen_pin_n_oe_o),
    .pin_pulldown_en_o(pin_pulldown_en_o),
    .dedicated_flag_output_o(dedicated_flag_output_o), .timer_clk_o(timer_clk_o)
);

// ===== gpp_ext.sv
`timescale 1ns/10ps
// Far-side drivers and the level each pad settles to
module gpp_ext
    import gpp_pkg::*;
(
    // Clock
    input  wire logic                core_clk_i,
    // Device side
    input  wire logic [NUM_PINS-1:0] dev_out_i,
    input  wire logic [NUM_PINS-1:0] dev_oe_i,
    input  wire logic [NUM_PINS-1:0] pd_en_i,
    // Outside source
    input  wire logic [NUM_PINS-1:0] ext_val_i,
    input  wire logic [NUM_PINS-1:0] ext_en_i,
    // Pad level
    output logic      [NUM_PINS-1:0] pad_o
);
    logic [NUM_PINS-1:0] last;
    // Floating pads without pulldown flip each cycle
    assign pad_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i & ext_val_i)
                 | (~dev_oe_i & ~ext_en_i & ~pd_en_i & ~last);
    always_ff @(posedge core_clk_i) begin
        last <= pad_o;
    end
endmodule : gpp_ext

// ===== testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    import gpp_pkg::*;
    logic                   core_clk_i = 1'b0;
    logic                   nrst_i = 1'b0;
    logic [ADDR_W-1:0]      addr_i = '0;
    logic [DATA_W-1:0]      wr_data_i = '0;
    logic                   wr_i = 1'b0;
    logic                   rd_i = 1'b0;
    logic [NUM_PINS-1:0]    ext_val = '0;
    logic [NUM_PINS-1:0]    ext_en = '0;
    logic [NUM_PINS-1:0]    periph_out = 26'h0000100;
    logic [NUM_PINS-1:0]    periph_oe = 26'h0000100;
    logic [DATA_W-1:0]      rd_data_o;
    logic                   irq_o;
    logic [NUM_PINS-1:0]    pad;
    logic [NUM_PINS-1:0]    pin_o;
    logic [NUM_PINS-1:0]    pin_oe;
    logic [NUM_PINS-1:0]    pd_en;
    logic [NUM_PINS-1:0]    periph_in;
    logic                   ded;
    logic [NUM_TMR_CLK-1:0] tmr;
    int                     fail_count = 0;
    int                     cmp_count = 0;
    always #2 core_clk_i = ~core_clk_i;
    gpp_port u_gpp_port (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
        .gen_pin_n_i(pad), .gen_pin_n_o(pin_o), .gen_pin_n_oe_o(pin_oe), .pin_pulldown_en_o(pd_en),
        .dedicated_flag_output_o(ded), .periph_out_i(periph_out), .periph_oe_i(periph_oe),
        .periph_in_o(periph_in), .timer_clk_o(tmr));
    gpp_ext u_gpp_ext (.core_clk_i(core_clk_i), .dev_out_i(pin_o), .dev_oe_i(pin_oe),
        .pd_en_i(pd_en), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad));
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge core_clk_i);
        wr_i      <= 1'b0;
    endtask : wr
    task automatic rdc(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(n, e, rd_data_o)
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic wait_irq(input logic lvl);
        int i;
        for (i = 0; i < IRQ_LAT_CYC && irq_o !== lvl; i++) cyc(1);
        `CHK("irq", lvl, irq_o)
        if (irq_o !== lvl) results();
    endtask : wait_irq
    initial begin
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        `CHK("pd_rst", {NUM_PINS{1'b1}}, pd_en)
        `CHK("oe_rst", '0, pin_oe)
        for (int a = 0; a <= 36; a += 4) rdc("reset", ADDR_W'(a), '0);
        wr(8'h40, 32'hFFFFFFFF);
        rdc("unmapped", 8'h40, '0);
        $display("test reset done");
        wr(REG_DIR, 32'h03FFFFFF);
        wr(REG_DOUT, 32'h0155AA55);
        cyc(6);
        `CHK("oe", {NUM_PINS{1'b1}}, pin_oe)
        `CHK("dout", 26'h155AA55, pin_o)
        rdc("dout_rd", REG_DOUT, 32'h0155AA55);
        wr(REG_DOUT, '0);
        wr(REG_DOUT, 32'h03FFFFFF);
        wr(REG_DOUT, 32'h02AAAAAA);
        cyc(8);
        `CHK("last_wins", 26'h2AAAAAA, pin_o)
        wr(REG_DED_OUT, 32'h00000001);
        cyc(6);
        `CHK("ded", 1'b1, ded)
        $display("test output done");
        wr(REG_DIR, '0);
        wr(REG_MUX_SEL, 32'h00000F00);
        wr(REG_PD_DIS, 32'h0000FF0F);
        @(posedge core_clk_i);
        ext_en  <= {NUM_PINS{1'b1}};
        ext_val <= 26'h2A5C3F1;
        cyc(2);
        rdc("din", REG_DIN, 32'h02A5C3F1);
        `CHK("tmr", 3'h1, tmr)
        `CHK("periph_in", 26'h0000300, periph_in)
        `CHK("pd", ~26'h000FF0F, pd_en)
        `CHK("periph_oe", 26'h0000100, pin_oe)
        `CHK("periph_out", 1'b1, pin_o[8])
        $display("test input done");
        @(posedge core_clk_i);
        ext_val <= '0;
        cyc(4);
        wr(REG_FLAG_CLR, 32'h03FFFFFF);
        wr(REG_INT_EN, 32'h00000020);
        rdc("flag_clr", REG_FLAG, '0);
        @(posedge core_clk_i);
        ext_val[5] <= 1'b1;
        wait_irq(1'b1);
        rdc("flag_rise", REG_FLAG, 32'h00000020);
        wr(REG_FLAG_CLR, 32'h00000020);
        wait_irq(1'b0);
        wr(REG_INT_EN, '0);
        wr(REG_EDGE_SEL, 32'h00000020);
        @(posedge core_clk_i);
        ext_val[5] <= 1'b0;
        cyc(8);
        `CHK("irq_masked", 1'b0, irq_o)
        rdc("flag_fall", REG_FLAG, 32'h00000020);
        wr(REG_INT_EN, 32'h00000020);
        wait_irq(1'b1);
        $display("test irq done");
        results();
    end
endmodule : testbench
